// [rtl/drive_status_map.svh]
// Register map, protocol codes and timing constants of the drive status bank.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef DRIVE_STATUS_MAP_SVH
`define DRIVE_STATUS_MAP_SVH

// Status word offsets, one word per holding register
`define REG_MODEL_ID 4'h0
`define REG_FIRMWARE_REV 4'h1
`define REG_NODE_NUMBER 4'h2
`define REG_OPERATING_MODE 4'h3
`define REG_MOTOR_ACTIVITY 4'h4
`define REG_ROTATION_DIR 4'h5
`define REG_FAULT_CODE 4'h6
`define REG_MOTION_FLAGS 4'h7
`define REG_INPUT_LEVELS 4'h8
`define REG_OUTPUT_LEVELS 4'h9
`define REG_POSITION_UPPER 4'hA
`define REG_POSITION_LOWER 4'hB
`define REG_COUNT 17'h0000C

// Motion flag bit positions
`define FLAG_POS_REACHED 0
`define FLAG_HOME_DONE 1
`define FLAG_TURNING 2
`define FLAG_ALARM 3
`define FLAG_RELEASED 4
`define FLAG_AT_TARGET 5

// Function codes, exception codes and addressing
`define FN_READ_HOLDING 8'h03
`define FN_WRITE_SINGLE 8'h06
`define FN_WRITE_MULTI 8'h10
`define FN_EXC_FLAG 8'h80
`define EXC_ILLEGAL_FN 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define NODE_BROADCAST 8'h00
`define MAX_READ_QTY 16'h007D
`define REQ_FIXED_LEN 8'h08
`define MIN_FRAME_LEN 8'h04

// Frame check
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001

// Timing
`define CLK_HZ 125000000
`define BAUD_DEFAULT 9600
`define FRAME_GAP_BITS 35

`endif

// [rtl/drive_status_pkg.sv]
// Types shared by the drive status bank and its serial character engines.
// Assumes nothing beyond a SystemVerilog compiler.
package drive_status_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
	typedef enum logic [1:0] {LINK_RX, LINK_CHECK, LINK_SEND, LINK_DRAIN} link_state_t;

	typedef struct packed {
		rx_state_t st;
		logic [15:0] cnt;
		logic [2:0] bit_idx;
		logic [7:0] shift;
		logic [7:0] data;
		logic valid;
	} rx_regs_t;

	typedef struct packed {
		tx_state_t st;
		logic [15:0] cnt;
		logic [2:0] bit_idx;
		logic [7:0] shift;
		logic line;
	} tx_regs_t;

	typedef struct packed {
		link_state_t st;
		logic [23:0] idle_cnt;
		logic [7:0] nbytes;
		logic [15:0] crc;
		logic [5:0][7:0] req;
		logic [11:0][15:0] snap;
		logic [7:0] exc;
		logic [3:0] start;
		logic [7:0] qty;
		logic [7:0] tx_idx;
		logic [7:0] tx_len;
		logic [15:0] tx_crc;
		logic de;
	} link_regs_t;

endpackage : drive_status_pkg

// [rtl/serial_char_rx.sv]
// Serial character receiver: start bit, 8 data bits LSB first, one stop bit.
// Assumes line_in is already synchronous to clk.
module serial_char_rx #(
	parameter int BIT_CYCLES = 13020
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Line and received character
	input wire logic line_in,
	output logic [7:0] char_data,
	output logic char_valid
);
	import drive_status_pkg::*;

	rx_regs_t r_r, r_nxt;
	localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2);

	// Elaboration refuses bit times the 16-bit counter cannot hold
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
		$error("BIT_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample each bit at its centre; a short start pulse is taken as noise
	always_comb begin
		r_nxt = r_r;
		r_nxt.valid = 1'b0;
		unique case (r_r.st)
			RX_IDLE: begin
				r_nxt.cnt = 16'h0000;
				if (!line_in) r_nxt.st = RX_START;
			end
			RX_START: begin
				r_nxt.cnt = r_r.cnt + 16'h0001;
				if (r_r.cnt == HALF) begin
					r_nxt.cnt = 16'h0000;
					r_nxt.bit_idx = 3'h0;
					r_nxt.st = line_in ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				r_nxt.cnt = r_r.cnt + 16'h0001;
				if (r_r.cnt == FULL) begin
					r_nxt.cnt = 16'h0000;
					r_nxt.shift = {line_in, r_r.shift[7:1]};
					r_nxt.bit_idx = r_r.bit_idx + 3'h1;
					if (r_r.bit_idx == 3'h7) r_nxt.st = RX_STOP;
				end
			end
			RX_STOP: begin
				r_nxt.cnt = r_r.cnt + 16'h0001;
				if (r_r.cnt == FULL) begin
					r_nxt.st = RX_IDLE;
					r_nxt.data = r_r.shift;
					r_nxt.valid = line_in; // Framing error drops the character
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) r_r <= '{st: RX_IDLE, default: '0};
		else r_r <= r_nxt;
	end

	assign char_data = r_r.data;
	assign char_valid = r_r.valid;

endmodule : serial_char_rx

// [rtl/serial_char_tx.sv]
// Serial character transmitter: start bit, 8 data bits LSB first, one stop bit.
// Assumes the source holds char_data while char_valid waits for char_ready.
module serial_char_tx #(
	parameter int BIT_CYCLES = 13020
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Character handshake
	input wire logic [7:0] char_data,
	input wire logic char_valid,
	output logic char_ready,
	output logic busy,
	// Line
	output logic line_out
);
	import drive_status_pkg::*;

	tx_regs_t r_r, r_nxt;
	localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);

	// Elaboration refuses bit times the 16-bit counter cannot hold
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
		$error("BIT_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// One bit period per state step; line idles high
	always_comb begin
		r_nxt = r_r;
		r_nxt.cnt = r_r.cnt + 16'h0001;
		unique case (r_r.st)
			TX_IDLE: begin
				r_nxt.cnt = 16'h0000;
				r_nxt.line = 1'b1;
				if (char_valid) begin
					r_nxt.shift = char_data;
					r_nxt.line = 1'b0;
					r_nxt.st = TX_START;
				end
			end
			TX_START, TX_DATA: begin
				if (r_r.cnt == FULL) begin
					r_nxt.cnt = 16'h0000;
					if (r_r.st == TX_START) r_nxt.bit_idx = 3'h0;
					else r_nxt.bit_idx = r_r.bit_idx + 3'h1;
					if (r_r.st == TX_DATA && r_r.bit_idx == 3'h7) begin
						r_nxt.line = 1'b1;
						r_nxt.st = TX_STOP;
					end else begin
						r_nxt.line = r_r.st == TX_START ? r_r.shift[0] : r_r.shift[1];
						if (r_r.st == TX_DATA) r_nxt.shift = {1'b0, r_r.shift[7:1]};
						r_nxt.st = TX_DATA;
					end
				end
			end
			TX_STOP: begin
				if (r_r.cnt == FULL) r_nxt.st = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) r_r <= '{st: TX_IDLE, line: 1'b1, default: '0};
		else r_r <= r_nxt;
	end

	assign char_ready = r_r.st == TX_IDLE;
	assign busy = r_r.st != TX_IDLE;
	assign line_out = r_r.line;

endmodule : serial_char_tx

// [rtl/drive_status_register_bank.sv]
// Read-only status holding registers of a stepper-servo drive, served to a
// serial bus master as RTU frames over a half-duplex differential link.
// Assumes the status inputs are synchronous to clk and the line transceiver
// routes line_out onto the pair while line_drive_en is high.
`include "drive_status_map.svh"

module drive_status_register_bank #(
	parameter int BIT_CYCLES = `CLK_HZ / `BAUD_DEFAULT,
	parameter logic [15:0] MODEL_ID = 16'hA5C3, // Arbitrary value
	parameter logic [15:0] FIRMWARE_REV = 16'h0A17 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link
	input wire logic line_in,
	output logic line_out,
	output logic line_drive_en,
	// Drive identity, mode and fault code
	input wire logic [7:0] node_number,
	input wire logic [1:0] operating_mode,
	input wire logic [2:0] fault_code,
	// Motion state
	input wire logic motor_turning,
	input wire logic rotating_clockwise,
	input wire logic position_reached,
	input wire logic homing_done,
	input wire logic alarm_active,
	input wire logic motor_released,
	input wire logic at_target,
	input wire logic [31:0] current_position,
	// Terminal levels, high when valid
	input wire logic pulse_input_terminal,
	input wire logic direction_input_terminal,
	input wire logic general_input_zero,
	input wire logic general_input_one,
	input wire logic general_input_two,
	input wire logic general_input_three,
	input wire logic general_input_four,
	input wire logic general_output_zero,
	input wire logic general_output_one,
	input wire logic general_output_two
);
	import drive_status_pkg::*;

	localparam logic [23:0] GAP_CYCLES = 24'(`FRAME_GAP_BITS * BIT_CYCLES);

	// Elaboration refuses bit times the counters cannot hold
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
		$error("BIT_CYCLES out of range");
	end
	if (`FRAME_GAP_BITS * BIT_CYCLES > 24'hFFFFFF) begin : g_bad_gap
		$error("Frame gap too long");
	end

	link_regs_t r_r, r_nxt;

	logic [7:0] rx_data;
	logic rx_valid;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic tx_busy;

	////////////////////////////////////////////////////////////////////////////
	// Character engines on the half-duplex link
	serial_char_rx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx (
		.clk(clk),
		.rst(rst),
		.line_in(line_in),
		.char_data(rx_data),
		.char_valid(rx_valid)
	);

	serial_char_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk(clk),
		.rst(rst),
		.char_data(tx_data),
		.char_valid(tx_valid),
		.char_ready(tx_ready),
		.busy(tx_busy),
		.line_out(line_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Frame check step, reflected polynomial, one byte at a time
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_step

	////////////////////////////////////////////////////////////////////////////
	// Live status words; reserved bits tie to zero
	logic [11:0][15:0] live;

	always_comb begin
		live = '0;
		live[`REG_MODEL_ID] = MODEL_ID;
		live[`REG_FIRMWARE_REV] = FIRMWARE_REV;
		live[`REG_NODE_NUMBER] = {8'h00, node_number};
		live[`REG_OPERATING_MODE] = {14'h0000, operating_mode};
		live[`REG_MOTOR_ACTIVITY] = {15'h0000, motor_turning};
		live[`REG_ROTATION_DIR] = {15'h0000, rotating_clockwise};
		live[`REG_FAULT_CODE] = {13'h0000, fault_code};
		// Bits 6 and up stay zero
		live[`REG_MOTION_FLAGS][`FLAG_POS_REACHED] = position_reached;
		live[`REG_MOTION_FLAGS][`FLAG_HOME_DONE] = homing_done;
		live[`REG_MOTION_FLAGS][`FLAG_TURNING] = motor_turning;
		live[`REG_MOTION_FLAGS][`FLAG_ALARM] = alarm_active;
		live[`REG_MOTION_FLAGS][`FLAG_RELEASED] = motor_released;
		live[`REG_MOTION_FLAGS][`FLAG_AT_TARGET] = at_target;
		// Terminal levels are already valid-high, passed straight through
		live[`REG_INPUT_LEVELS] = {9'h000, general_input_four, general_input_three,
			general_input_two, general_input_one, general_input_zero,
			direction_input_terminal, pulse_input_terminal};
		live[`REG_OUTPUT_LEVELS] = {13'h0000, general_output_two, general_output_one,
			general_output_zero};
		live[`REG_POSITION_UPPER] = current_position[31:16];
		live[`REG_POSITION_LOWER] = current_position[15:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Request decode on the captured header bytes
	logic [15:0] req_start;
	logic [15:0] req_qty;
	logic [16:0] req_end;
	logic frame_ok;
	logic [7:0] exc_code;
	logic fixed_len_ok;

	assign req_start = {r_r.req[2], r_r.req[3]};
	assign req_qty = {r_r.req[4], r_r.req[5]};
	assign req_end = {1'b0, req_start} + {1'b0, req_qty};
	// A clean remainder of zero proves the trailing check bytes
	assign frame_ok = r_r.nbytes >= `MIN_FRAME_LEN && r_r.crc == 16'h0000
		&& (r_r.req[0] == node_number || r_r.req[0] == `NODE_BROADCAST);
	assign fixed_len_ok = r_r.nbytes == `REQ_FIXED_LEN;

	always_comb begin
		exc_code = 8'h00;
		unique case (r_r.req[1])
			`FN_READ_HOLDING: begin
				if (req_qty == 16'h0000 || req_qty > `MAX_READ_QTY)
					exc_code = `EXC_ILLEGAL_VALUE;
				else if (req_end > `REG_COUNT)
					exc_code = `EXC_ILLEGAL_ADDR;
			end
			// Nothing here is writable, so writes are refused untouched
			`FN_WRITE_SINGLE, `FN_WRITE_MULTI: exc_code = `EXC_ILLEGAL_ADDR;
			default: exc_code = `EXC_ILLEGAL_FN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Reply byte at the current index: header, payload words, check bytes
	logic [7:0] body_idx;
	logic [3:0] word_sel;
	logic [15:0] word_val;

	assign body_idx = r_r.tx_idx - 8'h03;
	assign word_sel = r_r.start + body_idx[4:1];
	assign word_val = r_r.snap[word_sel];

	always_comb begin
		tx_data = 8'h00;
		if (r_r.tx_idx == 8'h00) begin
			tx_data = r_r.req[0];
		end else if (r_r.tx_idx == 8'h01) begin
			tx_data = r_r.exc != 8'h00 ? (r_r.req[1] | `FN_EXC_FLAG) : r_r.req[1];
		end else if (r_r.tx_idx == r_r.tx_len - 8'h02) begin
			tx_data = r_r.tx_crc[7:0]; // Check bytes go low byte first
		end else if (r_r.tx_idx == r_r.tx_len - 8'h01) begin
			tx_data = r_r.tx_crc[15:8];
		end else if (r_r.tx_idx == 8'h02) begin
			tx_data = r_r.exc != 8'h00 ? r_r.exc : {r_r.qty[6:0], 1'b0};
		end else begin
			// Each word goes high byte first
			tx_data = body_idx[0] ? word_val[7:0] : word_val[15:8];
		end
	end

	assign tx_valid = r_r.st == LINK_SEND;

	////////////////////////////////////////////////////////////////////////////
	// Link sequencing: collect a frame, judge it after the silent gap, answer
	always_comb begin
		r_nxt = r_r;
		unique case (r_r.st)
			LINK_RX: begin
				// Silence counted from the last low level seen on the line
				// A high tail of data bits already counts as silence
				if (!line_in) r_nxt.idle_cnt = 24'h000000;
				else if (r_r.idle_cnt != GAP_CYCLES) r_nxt.idle_cnt = r_r.idle_cnt + 24'h000001;
				if (rx_valid) begin
					if (r_r.nbytes < 8'h06) r_nxt.req[r_r.nbytes[2:0]] = rx_data;
					r_nxt.crc = crc_step(r_r.crc, rx_data);
					if (r_r.nbytes != 8'hFF) r_nxt.nbytes = r_r.nbytes + 8'h01;
				end
				if (r_r.idle_cnt == GAP_CYCLES - 24'h000001 && r_r.nbytes != 8'h00)
					r_nxt.st = LINK_CHECK;
			end
			LINK_CHECK: begin
				r_nxt.st = LINK_RX;
				r_nxt.nbytes = 8'h00;
				r_nxt.crc = `CRC_INIT;
				r_nxt.idle_cnt = 24'h000000;
				// Broadcasts and damaged or odd-length frames get no answer
				if (frame_ok && fixed_len_ok && r_r.req[0] != `NODE_BROADCAST) begin
					// One snapshot keeps both position halves coherent
					r_nxt.snap = live;
					r_nxt.exc = exc_code;
					r_nxt.start = req_start[3:0];
					r_nxt.qty = req_qty[7:0];
					r_nxt.tx_idx = 8'h00;
					r_nxt.tx_crc = `CRC_INIT;
					r_nxt.tx_len = exc_code != 8'h00 ? 8'h05 : 8'h05 + {req_qty[6:0], 1'b0};
					r_nxt.st = LINK_SEND;
				end
			end
			LINK_SEND: begin
				// Own echo and other traffic are ignored while talking
				if (tx_ready) begin
					if (r_r.tx_idx < r_r.tx_len - 8'h02)
						r_nxt.tx_crc = crc_step(r_r.tx_crc, tx_data);
					r_nxt.tx_idx = r_r.tx_idx + 8'h01;
					if (r_r.tx_idx == r_r.tx_len - 8'h01) r_nxt.st = LINK_DRAIN;
				end
			end
			LINK_DRAIN: begin
				// Hold the driver until the last stop bit has left
				if (!tx_busy) begin
					r_nxt.st = LINK_RX;
					r_nxt.idle_cnt = 24'h000000;
				end
			end
		endcase
		r_nxt.de = r_nxt.st == LINK_SEND || r_nxt.st == LINK_DRAIN;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) r_r <= '{st: LINK_RX, crc: `CRC_INIT, tx_crc: `CRC_INIT, default: '0};
		else r_r <= r_nxt;
	end

	assign line_drive_en = r_r.de;

endmodule : drive_status_register_bank

// [verification/drive_status_monitor.sv]
// Concurrent checks on the serial link pins of the drive status bank.
// Assumes one clock, asynchronous active-high reset and idle-high link lines.
module drive_status_monitor #(
	parameter int BIT_CYCLES = 13020
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_drive_en
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int GAP = 35 * BIT_CYCLES;
	localparam int REPLY_MAX = 32 * 10 * BIT_CYCLES;
	logic [23:0] quiet_r;
	logic [23:0] run_r;
	logic [23:0] drive_r;
	logic prev_r;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////
	// Quiet, level-run and drive counters; quiet and level-run saturate so idle never wraps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quiet_r <= '0;
			run_r <= '0;
			drive_r <= '0;
			prev_r <= 1'b1;
		end else begin
			quiet_r <= !line_in ? '0 : (&quiet_r ? quiet_r : quiet_r + 24'h000001);
			run_r <= (line_out != prev_r) ? 24'h000001 : (&run_r ? run_r : run_r + 24'h000001);
			drive_r <= line_drive_en ? drive_r + 24'h000001 : '0;
			prev_r <= line_out;
		end
	end

	////////////////////////////////////////////////////////////
	// Link behaviour
	chk_reset_idle: assert property ($fell(rst) |-> line_out && !line_drive_en)
		else $error("link not idle after reset release");
	chk_idle_high: assert property (!line_drive_en |-> line_out)
		else $error("line_out low while the driver is off");
	chk_gap_before: assert property ($rose(line_drive_en) |-> quiet_r >= GAP - 2 && quiet_r <= GAP + 8)
		else $error("reply not started one frame gap after the request");
	chk_start_bit: assert property ($rose(line_drive_en) |=> !line_out)
		else $error("driver enabled without a start bit");
	chk_enable_hold: assert property ($rose(line_drive_en) |=> line_drive_en [*7])
		else $error("driver dropped inside the first bit");
	chk_bit_width: assert property (line_drive_en && $rose(line_out) |-> run_r % BIT_CYCLES == 0)
		else $error("low run on line_out not whole bit times");
	chk_stop_done: assert property ($fell(line_drive_en) |-> line_out && run_r >= BIT_CYCLES)
		else $error("driver released before the stop bit ended");
	chk_reply_bound: assert property (line_drive_en |-> drive_r < REPLY_MAX)
		else $error("reply longer than the largest frame");
endmodule : drive_status_monitor

bind drive_status_register_bank drive_status_monitor #(.BIT_CYCLES(BIT_CYCLES)) drive_status_monitor_inst (
	.clk(clk), .rst(rst), .line_in(line_in), .line_out(line_out), .line_drive_en(line_drive_en));

// [verification/rtu_master.sv]
// Bus master model: sends request frames and collects reply characters.
// Assumes one clock shared with the drive and a bit time given in clocks.
module rtu_master #(
	parameter int BIT_CYCLES = 8
) (
	// Clock
	input wire logic clk,
	// Link
	output logic line_in,
	input wire logic line_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx_q [$];

	// Master holds the pair idle high between frames
	initial line_in = 1'b1;

	////////////////////////////////////////////////////////////
	// Frame check word, sent low byte first
	function automatic logic [15:0] crc16(input logic [7:0] b [$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16

	// Start, 8 data bits LSB first, one stop; bad flips bit 0 of the check word
	task automatic send(input logic [7:0] b [$], input logic bad);
		logic [15:0] c;
		logic [9:0] ch;
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i]) begin
			ch = {1'b1, b[i], 1'b0};
			for (int k = 0; k < 10; k++) begin
				@(posedge clk);
				#1 line_in = ch[k];
				repeat (BIT_CYCLES - 1) @(posedge clk);
			end
		end
	endtask : send

	// Sample reply chars at bit centres; ok drops on timeout or bad stop
	task automatic recv(input int n, output logic ok);
		logic [7:0] d;
		int t;
		rx_q.delete();
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (line_out !== 1'b0 && t < 50 * BIT_CYCLES) begin
				@(posedge clk);
				t++;
			end
			if (t >= 50 * BIT_CYCLES) ok = 1'b0;
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int k = 0; k < 8; k++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				d[k] = line_out;
			end
			repeat (BIT_CYCLES) @(posedge clk);
			if (line_out !== 1'b1) ok = 1'b0;
			rx_q.push_back(d);
		end
	endtask : recv
endmodule : rtu_master

// [verification/drive_status_register_bank_tb.sv]
// Self-checking bench: status words read over the serial link, then refusals.
// Assumes the bind in the monitor file and a shortened bit time.
module drive_status_register_bank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BIT = 8;
	localparam logic [15:0] MODEL_ID_T = 16'h5A3C; // Arbitrary value
	localparam logic [15:0] FW_T = 16'h0B28; // Arbitrary value
	typedef struct packed {
		logic [7:0] node;
		logic [1:0] mode;
		logic [2:0] fault;
		logic [6:0] st;
		logic [6:0] in_lv;
		logic [2:0] out_lv;
		logic [31:0] pos;
		logic [15:0] exp7;
		logic [15:0] exp8;
	} row_t;
	// st: bits 0-5 motion flags in word order, bit 6 clockwise
	row_t rows [3] = '{
		'{8'h11, 2'h0, 3'h0, 7'h00, 7'h00, 3'h0, 32'h00000000, 16'h0000, 16'h0000},
		'{8'h2A, 2'h1, 3'h5, 7'h7F, 7'h7F, 3'h7, 32'hFFFFFFFE, 16'h003F, 16'h007F},
		'{8'h7E, 2'h2, 3'h3, 7'h55, 7'h2A, 3'h5, 32'h12345678, 16'h0015, 16'h002A}};
	logic clk, rst, line_in, line_out, line_drive_en, ok;
	logic [7:0] node_number;
	logic [1:0] operating_mode;
	logic [2:0] fault_code;
	logic motor_turning, rotating_clockwise, position_reached, homing_done;
	logic alarm_active, motor_released, at_target;
	logic [31:0] current_position;
	logic pulse_input_terminal, direction_input_terminal, general_input_zero;
	logic general_input_one, general_input_two, general_input_three, general_input_four;
	logic general_output_zero, general_output_one, general_output_two;
	logic [7:0] q [$];
	int err_count = 0;
	int comparisons = 0;

	drive_status_register_bank #(.BIT_CYCLES(BIT), .MODEL_ID(MODEL_ID_T), .FIRMWARE_REV(FW_T))
		drive_status_register_bank_inst (.clk(clk), .rst(rst), .line_in(line_in),
		.line_out(line_out), .line_drive_en(line_drive_en), .node_number(node_number),
		.operating_mode(operating_mode), .fault_code(fault_code), .motor_turning(motor_turning),
		.rotating_clockwise(rotating_clockwise), .position_reached(position_reached),
		.homing_done(homing_done), .alarm_active(alarm_active), .motor_released(motor_released),
		.at_target(at_target), .current_position(current_position),
		.pulse_input_terminal(pulse_input_terminal),
		.direction_input_terminal(direction_input_terminal),
		.general_input_zero(general_input_zero), .general_input_one(general_input_one),
		.general_input_two(general_input_two), .general_input_three(general_input_three),
		.general_input_four(general_input_four), .general_output_zero(general_output_zero),
		.general_output_one(general_output_one), .general_output_two(general_output_two));
	rtu_master #(.BIT_CYCLES(BIT)) rtu_master_inst (.clk(clk), .line_in(line_in),
		.line_out(line_out));

	////////////////////////////////////////////////////////////
	// Clock, 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		final_report();
	end

	////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	function automatic logic [7:0] rb(input int i);
		return rtu_master_inst.rx_q[i];
	endfunction : rb

	function automatic logic [15:0] wd(input int i);
		return {rb(3 + 2 * i), rb(4 + 2 * i)};
	endfunction : wd

	task automatic apply(input row_t r);
		node_number = r.node;
		operating_mode = r.mode;
		fault_code = r.fault;
		{rotating_clockwise, at_target, motor_released, alarm_active, motor_turning,
			homing_done, position_reached} = r.st;
		{general_input_four, general_input_three, general_input_two, general_input_one,
			general_input_zero, direction_input_terminal, pulse_input_terminal} = r.in_lv;
		{general_output_two, general_output_one, general_output_zero} = r.out_lv;
		current_position = r.pos;
	endtask : apply

	// Idle gap, one request, n reply chars expected; n of 1 means silence
	task automatic xfer(input logic [7:0] nd, input logic [7:0] fn, input logic [7:0] a,
		input logic [15:0] v, input int n, input logic bad);
		repeat (40 * BIT) @(posedge clk);
		q = {nd, fn, 8'h00, a, v[15:8], v[7:0]};
		rtu_master_inst.send(q, bad);
		rtu_master_inst.recv(n, ok);
		check({15'h0000, ok}, {15'h0000, n > 1});
		if (ok === 1'b1) begin
			check({rb(n - 1), rb(n - 2)}, rtu_master_inst.crc16(rtu_master_inst.rx_q[0:$-2]));
			check({8'h00, rb(0)}, {8'h00, nd});
		end
	endtask : xfer

	////////////////////////////////////////////////////////////
	// Reset, table of status snapshots, then refusals and edge reads
	initial begin
		rst = 1'b1;
		apply(rows[0]);
		repeat (5) @(posedge clk);
		check({14'h0000, line_drive_en, line_out}, 16'h0001);
		#1 rst = 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			#1 apply(rows[i]);
			xfer(rows[i].node, 8'h03, 8'h00, 16'h000C, 29, 1'b0);
			check({rb(1), rb(2)}, 16'h0318);
			check(wd(0), MODEL_ID_T);
			check(wd(1), FW_T);
			check(wd(2), {8'h00, rows[i].node});
			check(wd(3), {14'h0000, rows[i].mode});
			check(wd(4), {15'h0000, rows[i].st[2]});
			check(wd(5), {15'h0000, rows[i].st[6]});
			check(wd(6), {13'h0000, rows[i].fault});
			check(wd(7), rows[i].exp7);
			check(wd(8), rows[i].exp8);
			check(wd(9), {13'h0000, rows[i].out_lv});
			check(wd(10), rows[i].pos[31:16]);
			check(wd(11), rows[i].pos[15:0]);
		end
		// Write refused, model word left as it was
		xfer(8'h7E, 8'h06, 8'h00, 16'hFFFF, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h8602);
		xfer(8'h7E, 8'h10, 8'h00, 16'h0001, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h9002);
		xfer(8'h7E, 8'h03, 8'h00, 16'h0001, 7, 1'b0);
		check(wd(0), MODEL_ID_T);
		// Past the last word, empty count, oversized count, unknown function
		xfer(8'h7E, 8'h03, 8'h0B, 16'h0002, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h8302);
		xfer(8'h7E, 8'h03, 8'h00, 16'h0000, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h8303);
		xfer(8'h7E, 8'h03, 8'h00, 16'h007E, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h8303);
		xfer(8'h7E, 8'h04, 8'h00, 16'h0001, 5, 1'b0);
		check({rb(1), rb(2)}, 16'h8401);
		// Sign boundary of the position, read as the last two words
		@(posedge clk);
		#1 current_position = 32'h80000001;
		xfer(8'h7E, 8'h03, 8'h0A, 16'h0002, 9, 1'b0);
		check(wd(0), 16'h8000);
		check(wd(1), 16'h0001);
		// Corrupt check word, foreign node and broadcast get no reply
		xfer(8'h7E, 8'h03, 8'h00, 16'h0001, 1, 1'b1);
		xfer(8'h7F, 8'h03, 8'h00, 16'h0001, 1, 1'b0);
		xfer(8'h00, 8'h03, 8'h00, 16'h0001, 1, 1'b0);
		final_report();
	end
endmodule : drive_status_register_bank_tb
